// ---- rtl/fthi_top.v ----
// Framer TDM highway interface: AXI4-Lite registers, elastic stores and highway serial ports.
`timescale 1ns/1ps
`include "fthi_defs.vh"
module fthi_top (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire highway_clk_i,
  input wire highway_frame_sync_i,
  output reg highway_frame_sync_o,
  output wire highway_frame_sync_oe_o,
  output reg tx_highway_data_a_o,
  output reg tx_highway_data_a_oe_o,
  output reg tx_highway_data_b_o,
  output reg tx_highway_data_b_oe_o,
  input wire rx_highway_data_a_i,
  input wire rx_highway_data_b_i,
  input wire rx_line_clk_i,
  input wire [7:0] rx_line_byte_i,
  input wire [4:0] rx_line_slot_i,
  input wire rx_line_byte_valid_i,
  input wire tx_line_req_i,
  input wire [4:0] tx_line_slot_i,
  output reg [7:0] tx_line_byte_o
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg [7:0] stuff_r, slip_r, hctl_r, txext_r, rxext_r, edge_r, txdat_r, rxdat_r, lidle_r, sidle_r;
  reg [31:0] txen_r, rxen_r;
  reg aw_ok_r, w_ok_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  wire slip_drop_set, slip_rep_set;

  wire hwy_en = hctl_r[`FTHI_B_HIGHWAY_ENABLE];
  wire master = hctl_r[`FTHI_B_MASTER];
  wire ds1 = stuff_r[`FTHI_B_DS1];
  wire [4:0] line_last = ds1 ? `FTHI_DS1_LAST : `FTHI_CEPT_LAST;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // Line slot to highway slot; stuffed slots are skipped over.
  function [4:0] map_slot;
    input [4:0] ln;
    input [2:0] pl;
    input is_ds1;
    reg [4:0] q;
    reg [4:0] rm;
    begin
      q = ln / 5'd3;
      rm = ln - q * 5'd3;
      if (!is_ds1 || pl[2]) map_slot = ln;
      else map_slot = {q[2:0], 2'b00} + rm + {4'd0, (rm[1:0] >= pl[1:0])};
    end
  endfunction

  function is_stuffed;
    input [4:0] s;
    input [2:0] pl;
    input is_ds1;
    begin
      if (!is_ds1) is_stuffed = 1'b0;
      else if (!pl[2]) is_stuffed = (s[1:0] == pl[1:0]);
      else is_stuffed = (s >= 5'd24);
    end
  endfunction

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_ok_r && !s_axi_bvalid;
  assign s_axi_wready = !w_ok_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire do_wr = aw_ok_r && w_ok_r && !s_axi_bvalid;
  wire do_rd = s_axi_arvalid && !s_axi_rvalid;

  reg [31:0] rd_mux;
  reg rd_hit;
  always @* begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    if (s_axi_araddr == `FTHI_A_STUFF) rd_mux = {24'h0, stuff_r};
    else if (s_axi_araddr == `FTHI_A_SLIP) rd_mux = {24'h0, slip_r};
    else if (s_axi_araddr == `FTHI_A_HCTL) rd_mux = {24'h0, hctl_r};
    else if (s_axi_araddr == `FTHI_A_TXEXT) rd_mux = {24'h0, txext_r};
    else if (s_axi_araddr == `FTHI_A_RXEXT) rd_mux = {24'h0, rxext_r};
    else if (s_axi_araddr == `FTHI_A_EDGE) rd_mux = {24'h0, edge_r};
    else if (s_axi_araddr == `FTHI_A_TXDAT) rd_mux = {24'h0, txdat_r};
    else if (s_axi_araddr == `FTHI_A_RXDAT) rd_mux = {24'h0, rxdat_r};
    else if (s_axi_araddr == `FTHI_A_TXEN) rd_mux = txen_r;
    else if (s_axi_araddr == `FTHI_A_RXEN) rd_mux = rxen_r;
    else if (s_axi_araddr == `FTHI_A_LIDLE) rd_mux = {24'h0, lidle_r};
    else if (s_axi_araddr == `FTHI_A_SIDLE) rd_mux = {24'h0, sidle_r};
    else rd_hit = 1'b0;
  end

  wire [31:0] wm = merge(32'h0, wdata_r, wstrb_r);
  wire wb0 = wstrb_r[0];
  wire slip_rd = do_rd && (s_axi_araddr == `FTHI_A_SLIP);

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FTHI_RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `FTHI_RESP_OK;
      s_axi_rdata <= 32'h0;
      stuff_r <= `FTHI_RST_STUFF;
      hctl_r <= `FTHI_RST_CTL;
      txext_r <= `FTHI_RST_CTL;
      rxext_r <= `FTHI_RST_CTL;
      edge_r <= `FTHI_RST_CTL;
      txdat_r <= `FTHI_RST_CTL;
      rxdat_r <= `FTHI_RST_CTL;
      txen_r <= `FTHI_RST_EN;
      rxen_r <= `FTHI_RST_EN;
      lidle_r <= `FTHI_RST_IDLE;
      sidle_r <= `FTHI_RST_IDLE;
      slip_r <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `FTHI_RESP_OK;
        if (awaddr_r == `FTHI_A_STUFF) begin
          if (wb0) stuff_r <= wm[7:0];
        end else if (awaddr_r == `FTHI_A_HCTL) begin
          if (wb0) hctl_r <= wm[7:0];
        end else if (awaddr_r == `FTHI_A_TXEXT) begin
          if (wb0) txext_r <= wm[7:0];
        end else if (awaddr_r == `FTHI_A_RXEXT) begin
          if (wb0) rxext_r <= wm[7:0];
        end else if (awaddr_r == `FTHI_A_EDGE) begin
          if (wb0) edge_r <= wm[7:0];
        end else if (awaddr_r == `FTHI_A_TXDAT) begin
          if (wb0) txdat_r <= wm[7:0];
        end else if (awaddr_r == `FTHI_A_RXDAT) begin
          if (wb0) rxdat_r <= wm[7:0];
        end else if (awaddr_r == `FTHI_A_TXEN) begin
          txen_r <= merge(txen_r, wdata_r, wstrb_r);
        end else if (awaddr_r == `FTHI_A_RXEN) begin
          rxen_r <= merge(rxen_r, wdata_r, wstrb_r);
        end else if (awaddr_r == `FTHI_A_LIDLE) begin
          if (wb0) lidle_r <= wm[7:0];
        end else if (awaddr_r == `FTHI_A_SIDLE) begin
          if (wb0) sidle_r <= wm[7:0];
        end else if (awaddr_r != `FTHI_A_SLIP) begin
          s_axi_bresp <= `FTHI_RESP_ERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_rd) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `FTHI_RESP_OK : `FTHI_RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      // A slip that lands in the reading cycle survives the clear.
      slip_r[`FTHI_B_SLIP_DROP] <= slip_drop_set | (slip_r[`FTHI_B_SLIP_DROP] & !slip_rd);
      slip_r[`FTHI_B_SLIP_REP] <= slip_rep_set | (slip_r[`FTHI_B_SLIP_REP] & !slip_rd);
    end
  end

  // ---------------------------------------------------------------
  // Pin sampling and edge detection
  // ---------------------------------------------------------------
  wire [4:0] pins_s;
  fthi_sync #(.W(5)) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({rx_line_clk_i, rx_highway_data_b_i, rx_highway_data_a_i, highway_frame_sync_i, highway_clk_i}),
    .sync_o(pins_s)
  );
  reg hclk_d_r, lclk_d_r;
  wire h_rise = pins_s[0] && !hclk_d_r;
  wire h_fall = !pins_s[0] && hclk_d_r;
  wire l_rise = pins_s[4] && !lclk_d_r;

  // ---------------------------------------------------------------
  // Frame sync generation from the received line clock
  // ---------------------------------------------------------------
  reg [7:0] lcnt_r;
  reg fs_arm_r;
  wire [7:0] lterm = ds1 ? `FTHI_DS1_LINE_TERM : `FTHI_CEPT_LINE_TERM;
  wire gen_pulse = l_rise && (lcnt_r == lterm);
  wire fs_opp_edge = edge_r[`FTHI_B_TXSYNC] ? h_fall : h_rise;
  assign highway_frame_sync_oe_o = master;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      hclk_d_r <= 1'b0;
      lclk_d_r <= 1'b0;
      lcnt_r <= 8'h00;
      fs_arm_r <= 1'b0;
      highway_frame_sync_o <= 1'b0;
    end else begin
      hclk_d_r <= pins_s[0];
      lclk_d_r <= pins_s[4];
      if (l_rise) lcnt_r <= gen_pulse ? 8'h00 : lcnt_r + 8'h01;
      if (gen_pulse) fs_arm_r <= 1'b1;
      // The strobe changes on the edge opposite the sampling edge so it is centred on it.
      if (fs_opp_edge) begin
        highway_frame_sync_o <= master && fs_arm_r;
        if (!gen_pulse) fs_arm_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Output highway: receive elastic store toward the system
  // ---------------------------------------------------------------
  reg [7:0] rxs_mem [0:63];
  reg rxw_half_r, rxr_half_r;
  reg [1:0] rx_fill_r;
  reg [10:0] tpos_r;
  reg tfs_pend_r;
  wire [1:0] t_rate = (hctl_r[3:2] == 2'b11) ? 2'b10 : hctl_r[3:2];
  wire t_dedge = txdat_r[`FTHI_B_DEDGE] ? h_rise : h_fall;
  wire t_sedge = edge_r[`FTHI_B_TXSYNC] ? h_rise : h_fall;
  wire t_fs = master ? highway_frame_sync_o : pins_s[1];
  wire [11:0] t_fbits = `FTHI_BASE_FRAME_BITS << t_rate;
  wire [10:0] t_cur = tfs_pend_r ? 11'd0 : tpos_r;
  wire [11:0] t_off = {txext_r[0], txdat_r[5:0], 3'b000} + {9'd0, edge_r[2:0]};
  wire [11:0] t_diff = {1'b0, t_cur} - t_off;
  wire [11:0] t_eff = t_diff[11] ? t_diff + t_fbits : t_diff;
  wire t_dts = txext_r[`FTHI_B_DTS] && (t_rate != 2'b00);
  wire t_valid = t_dts ? (!t_eff[3] && t_eff[10:9] == 2'b00) : (t_eff[10:8] == 3'b000);
  wire [4:0] t_slot = t_dts ? t_eff[8:4] : t_eff[7:3];
  wire [7:0] t_byte = is_stuffed(t_slot, stuff_r[2:0], ds1) ? sidle_r : rxs_mem[{rxr_half_r, t_slot}];
  wire t_drive = hwy_en && t_valid && txen_r[t_slot];
  wire t_bit = t_byte[3'd7 - t_eff[2:0]];
  wire t_frame_end = t_dedge && (t_eff == t_fbits - 12'd1);
  wire rx_line_end = rx_line_byte_valid_i && (rx_line_slot_i == line_last);
  wire [1:0] fill_now = rx_fill_r + {1'b0, rx_line_end && (rx_fill_r != 2'b11)};
  // Slip decisions are taken only at the highway frame boundary.
  assign slip_rep_set = t_frame_end && (fill_now == 2'b00);
  assign slip_drop_set = t_frame_end && fill_now[1];

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      rxw_half_r <= 1'b0;
      rxr_half_r <= 1'b1;
      rx_fill_r <= 2'b00;
      tpos_r <= 11'd0;
      tfs_pend_r <= 1'b0;
      tx_highway_data_a_o <= 1'b0;
      tx_highway_data_a_oe_o <= 1'b0;
      tx_highway_data_b_o <= 1'b0;
      tx_highway_data_b_oe_o <= 1'b0;
    end else begin
      if (rx_line_byte_valid_i) begin
        rxs_mem[{rxw_half_r, map_slot(rx_line_slot_i, stuff_r[2:0], ds1)}] <= rx_line_byte_i;
      end
      if (rx_line_end) rxw_half_r <= !rxw_half_r;
      rx_fill_r <= fill_now;
      if (t_sedge && t_fs) tfs_pend_r <= 1'b1;
      if (t_dedge) begin
        tfs_pend_r <= t_sedge && t_fs;
        tpos_r <= (t_cur == t_fbits[10:0] - 11'd1) ? 11'd0 : t_cur + 11'd1;
        tx_highway_data_a_o <= t_bit;
        tx_highway_data_b_o <= t_bit;
        tx_highway_data_a_oe_o <= t_drive && !txext_r[`FTHI_B_PORTB];
        tx_highway_data_b_oe_o <= t_drive && txext_r[`FTHI_B_PORTB];
      end
      // With no new frame the read half is kept and repeated; otherwise the newest frame is read.
      if (t_frame_end && (fill_now != 2'b00)) begin
        rxr_half_r <= rx_line_end ? rxw_half_r : !rxw_half_r;
        rx_fill_r <= 2'b00;
      end
    end
  end

  // ---------------------------------------------------------------
  // Input highway: transmit elastic store toward the line
  // ---------------------------------------------------------------
  reg [7:0] txs_mem [0:63];
  reg txw_half_r, txr_half_r;
  reg [10:0] rpos_r;
  reg rfs_pend_r;
  reg [6:0] rsh_r;
  wire [1:0] r_rate = (rxext_r[4:3] == 2'b11) ? 2'b10 : rxext_r[4:3];
  wire r_dedge = rxdat_r[`FTHI_B_DEDGE] ? h_rise : h_fall;
  wire r_sedge = edge_r[`FTHI_B_RXSYNC] ? h_rise : h_fall;
  wire [11:0] r_fbits = `FTHI_BASE_FRAME_BITS << r_rate;
  wire [10:0] r_cur = rfs_pend_r ? 11'd0 : rpos_r;
  wire [11:0] r_off = {rxext_r[0], rxdat_r[5:0], 3'b000} + {9'd0, edge_r[6:4]};
  wire [11:0] r_diff = {1'b0, r_cur} - r_off;
  wire [11:0] r_eff = r_diff[11] ? r_diff + r_fbits : r_diff;
  wire r_dts = rxext_r[`FTHI_B_DTS] && (r_rate != 2'b00);
  wire r_valid = r_dts ? (!r_eff[3] && r_eff[10:9] == 2'b00) : (r_eff[10:8] == 3'b000);
  wire [4:0] r_slot = r_dts ? r_eff[8:4] : r_eff[7:3];
  wire r_in = rxext_r[`FTHI_B_PORTB] ? pins_s[3] : pins_s[2];
  wire [4:0] tl_sys = map_slot(tx_line_slot_i, stuff_r[2:0], ds1);

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      txw_half_r <= 1'b0;
      txr_half_r <= 1'b1;
      rpos_r <= 11'd0;
      rfs_pend_r <= 1'b0;
      rsh_r <= 7'd0;
      tx_line_byte_o <= `FTHI_RST_IDLE;
    end else begin
      if (r_sedge && pins_s[1]) rfs_pend_r <= 1'b1;
      if (r_dedge) begin
        rfs_pend_r <= r_sedge && pins_s[1];
        rpos_r <= (r_cur == r_fbits[10:0] - 11'd1) ? 11'd0 : r_cur + 11'd1;
        rsh_r <= {rsh_r[5:0], r_in};
        if (r_valid && hwy_en && r_eff[2:0] == 3'd7) begin
          txs_mem[{txw_half_r, r_slot}] <= {rsh_r, r_in};
        end
        if (r_eff == r_fbits - 12'd1) txw_half_r <= !txw_half_r;
      end
      if (tx_line_req_i) begin
        // Payload toward the line is idle code while the highway or the slot is disabled.
        tx_line_byte_o <= (!hwy_en || !rxen_r[tl_sys]) ? lidle_r : txs_mem[{txr_half_r, tl_sys}];
        if (tx_line_slot_i == line_last) txr_half_r <= !txw_half_r;
      end
    end
  end
endmodule // fthi_top

// ---- rtl/fthi_defs.vh ----
// Constants for the framer TDM highway interface: register map, fields, reset values, timing.
`ifndef FTHI_DEFS_VH
`define FTHI_DEFS_VH

`define FTHI_AW 8
`define FTHI_A_STUFF 8'h00
`define FTHI_A_SLIP 8'h04
`define FTHI_A_HCTL 8'h08
`define FTHI_A_TXEXT 8'h0c
`define FTHI_A_RXEXT 8'h10
`define FTHI_A_EDGE 8'h14
`define FTHI_A_TXDAT 8'h18
`define FTHI_A_RXDAT 8'h1c
`define FTHI_A_TXEN 8'h20
`define FTHI_A_RXEN 8'h24
`define FTHI_A_LIDLE 8'h28
`define FTHI_A_SIDLE 8'h2c

`define FTHI_B_DS1 7
`define FTHI_B_SLIP_REP 6
`define FTHI_B_SLIP_DROP 7
`define FTHI_B_HIGHWAY_ENABLE 7
`define FTHI_B_MASTER 4
`define FTHI_B_DTS 1
`define FTHI_B_PORTB 2
`define FTHI_B_TXSYNC 3
`define FTHI_B_RXSYNC 7
`define FTHI_B_DEDGE 6

`define FTHI_RST_STUFF 8'h84
`define FTHI_RST_CTL 8'h00
`define FTHI_RST_EN 32'hffffffff
`define FTHI_RST_IDLE 8'hff

`define FTHI_DS1_LAST 5'd23
`define FTHI_CEPT_LAST 5'd31
`define FTHI_DS1_LINE_TERM 8'd192
`define FTHI_CEPT_LINE_TERM 8'd255
`define FTHI_BASE_FRAME_BITS 12'd256
`define FTHI_SLOTS 32
`define FTHI_RESP_OK 2'b00
`define FTHI_RESP_ERR 2'b10

`endif

// ---- rtl/fthi_sync.v ----
// Two flip-flop synchroniser for pins arriving from outside the clock domain.
`timescale 1ns/1ps
module fthi_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule // fthi_sync

// ---- tb/fthi_properties.sv ----
// Checker of bus handshakes and highway pin relations at the top ports.
`timescale 1ns/1ps
module fthi_properties (
  input wire clk_i,
  input wire sys_rst_i,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire highway_frame_sync_o,
  input wire highway_frame_sync_oe_o,
  input wire tx_highway_data_a_oe_o,
  input wire tx_highway_data_b_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  rd_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not inverse of rvalid");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10)
    else $error("bad write response code");
  port_excl_a: assert property (!(tx_highway_data_a_oe_o && tx_highway_data_b_oe_o))
    else $error("both output ports driven");
  fs_width_a: assert property ($rose(highway_frame_sync_o) |-> highway_frame_sync_o [*6])
    else $error("frame sync pulse too short");
  fs_drive_a: assert property ($rose(highway_frame_sync_o) |-> highway_frame_sync_oe_o)
    else $error("frame sync pulsed while not driven");
  wr_done_c: cover property (s_axi_bvalid && s_axi_bready);
  rd_done_c: cover property (s_axi_rvalid && s_axi_rready);
  fs_rise_c: cover property ($rose(highway_frame_sync_o));
  port_b_c: cover property (tx_highway_data_b_oe_o);
endmodule // fthi_properties

// ---- tb/fthi_hwy_model.sv ----
// Backplane highway model: highway clock, frame sync, input data and output capture.
`timescale 1ns/1ps
module fthi_hwy_model (
  input wire tx_a_i,
  input wire tx_a_oe_i,
  input wire tx_b_oe_i,
  output logic hclk_o,
  output logic fs_o,
  output logic rx_a_o,
  output logic rx_b_o
);
  logic [7:0] cnt = 8'h00;
  logic [7:0] sh = 8'h00;
  logic [7:0] cap [0:31];
  int oe_a = 0;
  int oe_b = 0;
  // The odd start offset puts every highway clock edge 0.5 ns before a system clock rising edge, never on one.
  initial begin
    hclk_o = 1'b0;
    fs_o = 1'b0;
    rx_a_o = 1'b0;
    rx_b_o = 1'b0;
    #37;
    forever #100 hclk_o = ~hclk_o;
  end
  always @(posedge hclk_o) begin
    cnt <= cnt + 8'h01;
    fs_o <= (cnt == 8'hff);
    rx_a_o <= cnt[0] ^ cnt[3];
    rx_b_o <= ~cnt[1];
    sh <= {sh[6:0], tx_a_i};
    // Bits leave one highway clock after the strobe period, so slot k ends at count 8k+8.
    if (cnt[2:0] == 3'd0) begin
      cap[cnt[7:3] - 5'd1] <= {sh[6:0], tx_a_i};
    end
    if (tx_a_oe_i) begin
      oe_a <= oe_a + 1;
    end
    if (tx_b_oe_i) begin
      oe_b <= oe_b + 1;
    end
  end
endmodule // fthi_hwy_model

// ---- tb/framer_tdm_highway_interface_bench.sv ----
// Self-checking bench of the highway interface: registers, line idle codes, highway ports, slips, master sync.
`timescale 1ns/1ps
`include "fthi_defs.vh"
module framer_tdm_highway_interface_bench;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] lbyte = 8'h00;
  logic [4:0] lslot = 5'h00;
  logic lvalid = 1'b0;
  logic lreq = 1'b0;
  logic [4:0] rslot = 5'h00;
  logic lclk = 1'b0;
  int cyc = 0;
  int n_fail = 0;
  int n_tests = 0;
  wire awready, wready, bvalid, arready, rvalid, hclk, mfs, fs_o, fs_oe, ta, ta_oe, tb, tb_oe, ra, rb;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] lout;
  wire fs_pin = fs_oe ? fs_o : mfs;
  // The model watches whichever port drives; a released line toggles so a stale level never passes for data.
  wire ta_pin = ta_oe ? ta : (tb_oe ? tb : cyc[0]);
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc % 8 == 7) begin
      lclk <= ~lclk;
    end
  end
  fthi_top uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .highway_clk_i(hclk), .highway_frame_sync_i(fs_pin),
    .highway_frame_sync_o(fs_o), .highway_frame_sync_oe_o(fs_oe), .tx_highway_data_a_o(ta),
    .tx_highway_data_a_oe_o(ta_oe), .tx_highway_data_b_o(tb), .tx_highway_data_b_oe_o(tb_oe),
    .rx_highway_data_a_i(ra), .rx_highway_data_b_i(rb), .rx_line_clk_i(lclk), .rx_line_byte_i(lbyte),
    .rx_line_slot_i(lslot), .rx_line_byte_valid_i(lvalid), .tx_line_req_i(lreq), .tx_line_slot_i(rslot),
    .tx_line_byte_o(lout));
  fthi_hwy_model mdl (.tx_a_i(ta_pin), .tx_a_oe_i(ta_oe), .tx_b_oe_i(tb_oe), .hclk_o(hclk), .fs_o(mfs),
    .rx_a_o(ra), .rx_b_o(rb));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        chk(32'(bresp), 32'(er));
        bready <= 1'b0;
      end
    end while (bready);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        chk(rdata & m, e);
        chk(32'(rresp), 32'(er));
        rready <= 1'b0;
      end
    end while (rready);
  endtask
  task automatic line_req(input logic [4:0] s, input logic [7:0] e);
    rslot <= s;
    lreq <= 1'b1;
    @(posedge clk_i);
    lreq <= 1'b0;
    @(posedge clk_i);
    chk(32'(lout), 32'(e));
  endtask
  // Counts output enables over one whole base-rate frame after the new setting has settled.
  task automatic oe_span(output int da, output int db);
    repeat (300) @(posedge clk_i);
    da = mdl.oe_a;
    db = mdl.oe_b;
    repeat (2048) @(posedge clk_i);
    da = mdl.oe_a - da;
    db = mdl.oe_b - db;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd_chk(`FTHI_A_STUFF, 32'hffffffff, 32'h84, 2'b00);
    rd_chk(`FTHI_A_HCTL, 32'hffffffff, 32'h0, 2'b00);
    rd_chk(`FTHI_A_TXEN, 32'hffffffff, 32'hffffffff, 2'b00);
    rd_chk(`FTHI_A_SIDLE, 32'hffffffff, 32'hff, 2'b00);
    axi_wr(`FTHI_A_EDGE, 32'ha5, 2'b00);
    rd_chk(`FTHI_A_EDGE, 32'hffffffff, 32'ha5, 2'b00);
    axi_wr(`FTHI_A_EDGE, 32'h0, 2'b00);
    axi_wr(`FTHI_A_SLIP, 32'hff, 2'b00);
    rd_chk(`FTHI_A_SLIP, 32'hffffff3f, 32'h0, 2'b00);
    axi_wr(8'h40, 32'h1, 2'b10);
    rd_chk(8'h40, 32'hffffffff, 32'h0, 2'b10);
  endtask
  task automatic t_idle;
    axi_wr(`FTHI_A_LIDLE, 32'h5a, 2'b00);
    line_req(5'd3, 8'h5a);
    axi_wr(`FTHI_A_HCTL, 32'h80, 2'b00);
    axi_wr(`FTHI_A_RXEN, 32'h0, 2'b00);
    line_req(5'd3, 8'h5a);
    axi_wr(`FTHI_A_RXEN, 32'hffffffff, 2'b00);
  endtask
  task automatic t_oe;
    int da;
    int db;
    oe_span(da, db);
    chk(32'(da >= 250), 32'h1);
    chk(32'(mdl.cap[28]), 32'hff);
    axi_wr(`FTHI_A_TXEN, 32'h0, 2'b00);
    oe_span(da, db);
    chk(32'(da), 32'h0);
    axi_wr(`FTHI_A_TXEN, 32'hffffffff, 2'b00);
    axi_wr(`FTHI_A_TXEXT, 32'h4, 2'b00);
    oe_span(da, db);
    chk(32'(da), 32'h0);
    chk(32'(db >= 250), 32'h1);
    chk(32'(mdl.cap[28]), 32'hff);
    axi_wr(`FTHI_A_TXEXT, 32'h0, 2'b00);
    axi_wr(`FTHI_A_HCTL, 32'h0, 2'b00);
    oe_span(da, db);
    chk(32'(da + db), 32'h0);
    axi_wr(`FTHI_A_HCTL, 32'h80, 2'b00);
    // The model sends 55 in even and aa in odd slots; the store still holds frames from the enabled spans.
    line_req(5'd3, 8'haa);
    line_req(5'd4, 8'h55);
  endtask
  // Slot 28 lies inside the grouped stuffed region of the reset placement.
  task automatic t_stuff;
    axi_wr(`FTHI_A_SIDLE, 32'h0, 2'b00);
    repeat (4200) @(posedge clk_i);
    chk(32'(mdl.cap[28]), 32'h0);
  endtask
  task automatic t_slip;
    rd_chk(`FTHI_A_SLIP, 32'h40, 32'h40, 2'b00);
    rd_chk(`FTHI_A_SLIP, 32'hc0, 32'h0, 2'b00);
    for (int i = 0; i < 72; i++) begin
      lbyte <= 8'(i);
      lslot <= 5'(i % 24);
      lvalid <= 1'b1;
      @(posedge clk_i);
    end
    lvalid <= 1'b0;
    repeat (2200) @(posedge clk_i);
    rd_chk(`FTHI_A_SLIP, 32'h80, 32'h80, 2'b00);
  endtask
  // Every fourth slot from the second is stuffed, so highway slot 30 carries line slot 22.
  task automatic t_place;
    axi_wr(`FTHI_A_STUFF, 32'h81, 2'b00);
    for (int i = 0; i < 48; i++) begin
      lbyte <= 8'h30 + 8'(i % 24);
      lslot <= 5'(i % 24);
      lvalid <= 1'b1;
      @(posedge clk_i);
    end
    lvalid <= 1'b0;
    repeat (4200) @(posedge clk_i);
    chk(32'(mdl.cap[29]), 32'h0);
    chk(32'(mdl.cap[30]), 32'h46);
  endtask
  task automatic t_master;
    int t0;
    axi_wr(`FTHI_A_HCTL, 32'h90, 2'b00);
    chk(32'(fs_oe), 32'h1);
    @(posedge fs_o);
    t0 = cyc;
    @(posedge fs_o);
    chk(32'(cyc - t0 >= 3086 && cyc - t0 <= 3090), 32'h1);
    repeat (20) @(posedge clk_i);
    axi_wr(`FTHI_A_HCTL, 32'h80, 2'b00);
    chk(32'(fs_oe), 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_idle();
    t_oe();
    t_stuff();
    t_slip();
    t_place();
    t_master();
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    end_sim();
  end
endmodule // framer_tdm_highway_interface_bench
bind fthi_top fthi_properties u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .highway_frame_sync_o(highway_frame_sync_o),
  .highway_frame_sync_oe_o(highway_frame_sync_oe_o), .tx_highway_data_a_oe_o(tx_highway_data_a_oe_o),
  .tx_highway_data_b_oe_o(tx_highway_data_b_oe_o));
